// *** rtl/clkdist_pkg.sv ***
// Shared constants, register map and types for the output clock distribution.
package clkdist_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W          = 13;
    localparam logic [11:0] IDX_SETTINGS    = 12'h400;
    localparam logic [11:0] IDX_ENABLE      = 12'h401;
    localparam logic [11:0] IDX_CH0_MODE    = 12'h404;
    localparam logic [11:0] IDX_CH1_MODE    = 12'h405;
    localparam logic [11:0] IDX_CH0_DIVIDER = 12'h410;
    localparam logic [11:0] IDX_CH1_DIVIDER = 12'h411;
    localparam logic [11:0] IDX_STATUS      = 12'h412;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned SET_PD0_BIT     = 0;
    localparam int unsigned SET_PD1_BIT     = 1;
    localparam int unsigned SET_HF_RX_BIT   = 4;
    localparam int unsigned STAT_SLEEP_BIT  = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  SETTINGS_RST    = 8'h00;
    localparam logic [7:0]  ENABLE_RST      = 8'h03;
    localparam logic [7:0]  MODE_RST        = 8'h00;
    localparam logic [29:0] DIVIDER_RST     = 30'h0000_0000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        MODE_CMOS_BOTH   = 3'h0,
        MODE_CMOS_POS    = 3'h1,
        MODE_CMOS_NEG    = 3'h2,
        MODE_TRISTATE    = 3'h3,
        MODE_LVDS        = 3'h4,
        MODE_LVPECL      = 3'h5,
        MODE_UNUSED6     = 3'h6,
        MODE_UNUSED7     = 3'h7
    } out_mode_e;

    // Layout of a channel mode register.
    typedef struct packed
    {
        logic [1:0] spare;
        logic       cmos_phase_inv;
        logic       polarity_inv;
        logic       strong_drive;
        out_mode_e  mode;
    } chan_mode_s;

    // Pin drive of one channel; an oe_n low means the pin is driven.
    typedef struct packed
    {
        logic channel_positive_pin;
        logic positive_oe_n;
        logic channel_negative_pin;
        logic negative_oe_n;
        logic strong_drive;
    } chan_pins_s;

endpackage

// *** rtl/output_clock_divider_distribution.sv ***
// Two-channel output clock divider and driver stage with an APB slave.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// How it works
// - 30-bit divider, ratio is value plus one
// - Even ratios give exact half duty
// - Ratio one passes input duty through
// - Odd ratios high fraction (N+2X-1)/2N
// - Move falling edge, rising when inverted
// - Per-channel power-down shuts only its driver
// - Both powered down gives deep sleep
// - CMOS disable stalls at static level
// - Tristate silences pins, divider keeps aligned
// - Enable changes land on period boundaries
// - Same ratio channels start together
// - Mode bits 2..0 choose family, pins
// - Mode decode: CMOS variants, LVDS, LVPECL
// - Polarity invert swaps levels, default normal
// - CMOS phase invert complements negative pin
// - Drive bit weak/strong, LVPECL ignores
// - Settings bit four picks fast receiver
// - Drive strength sits at mode bit three
// ----------------------------------------------------------------------
module output_clock_divider_distribution
    import clkdist_pkg::*;
#(
    parameter int unsigned NUM_CH = 2,
    parameter int unsigned DIV_W  = 30
)
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic                  distribution_input_clock,
    output var  logic                  hf_receiver_sel,
    output var  logic                  deep_sleep,
    output var  chan_pins_s [NUM_CH-1:0] channel_output
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Byte address of a register index.
    // Registers sit on whole words, so the two low address bits are
    // always zero and the index is shifted up by two.
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
        byte_addr = {idx[ADDR_W-3:0], 2'b00};
    endfunction

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Map in byte addresses: settings at 0x1000, enable at 0x1004, the
    // two mode registers at 0x1010 and 0x1014, the two divider words at
    // 0x1040 and 0x1044 and the read-only status word at 0x1048.
    // Settings: bit 0 and bit 1 power the channels down, bit 4 picks
    // the fast receiver. Enable: one bit per channel. Mode: family in
    // bits 2..0, drive in bit 3, polarity in bit 4, phase in bit 5.
    // Bits above a register's width read as zero and ignore writes.
    logic [7:0]       settings_ff;
    logic [7:0]       enable_ff;
    chan_mode_s       mode_ff    [NUM_CH];
    logic [DIV_W-1:0] divider_ff [NUM_CH];
    logic [31:0]      nxt_prdata;
    logic             nxt_slverr;
    logic             wr_en;
    logic             in_ff;
    logic             in_rise;
    logic             in_fall;
    logic             sleep;
    logic [NUM_CH-1:0] active_ff;

    // Writes land only in the access phase, when pready is seen high.
    assign wr_en = psel & penable & pwrite & pready;

    // Software state; the drive bit is field strong_drive at bit 3.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            settings_ff <= SETTINGS_RST;
            enable_ff   <= ENABLE_RST;
            for (int c = 0; c < NUM_CH; c++)
            begin
                mode_ff[c]    <= chan_mode_s'(MODE_RST);
                divider_ff[c] <= DIVIDER_RST[DIV_W-1:0];
            end
        end
        else if (wr_en)
        begin
            if (paddr == byte_addr(IDX_SETTINGS))
                settings_ff <= pwdata[7:0];
            if (paddr == byte_addr(IDX_ENABLE))
                enable_ff <= pwdata[7:0];
            if (paddr == byte_addr(IDX_CH0_MODE))
                mode_ff[0] <= chan_mode_s'(pwdata[7:0]);
            if (paddr == byte_addr(IDX_CH1_MODE))
                mode_ff[1] <= chan_mode_s'(pwdata[7:0]);
            if (paddr == byte_addr(IDX_CH0_DIVIDER))
                divider_ff[0] <= pwdata[DIV_W-1:0];
            if (paddr == byte_addr(IDX_CH1_DIVIDER))
                divider_ff[1] <= pwdata[DIV_W-1:0];
        end
    end

    // Read mux, decoded in the setup phase so data stands in the access.
    always_comb
    begin
        nxt_prdata = 32'h0000_0000;
        nxt_slverr = 1'b0;
        if (paddr == byte_addr(IDX_SETTINGS))
            nxt_prdata[7:0] = settings_ff;
        else if (paddr == byte_addr(IDX_ENABLE))
            nxt_prdata[7:0] = enable_ff;
        else if (paddr == byte_addr(IDX_CH0_MODE))
            nxt_prdata[7:0] = mode_ff[0];
        else if (paddr == byte_addr(IDX_CH1_MODE))
            nxt_prdata[7:0] = mode_ff[1];
        else if (paddr == byte_addr(IDX_CH0_DIVIDER))
            nxt_prdata[DIV_W-1:0] = divider_ff[0];
        else if (paddr == byte_addr(IDX_CH1_DIVIDER))
            nxt_prdata[DIV_W-1:0] = divider_ff[1];
        else if (paddr == byte_addr(IDX_STATUS))
            nxt_prdata[2:0] = {sleep, active_ff};
        else
            nxt_slverr = 1'b1;
    end

    // APB answer: fixed one wait-free access phase after each setup.
    // The answer is registered, so pready comes exactly one cycle after
    // the setup edge and stands for one cycle only. Read data is zero
    // outside that cycle, which keeps a stale word off the bus. An
    // unmapped address answers with pslverr and the write is dropped.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pready  <= 1'b1;
            pslverr <= nxt_slverr;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Input clock sampling
    // ------------------------------------------------------------------

    // The distribution clock is sampled like data; edges come from the
    // previous sample, so its frequency must stay below half of clk.
    // The price of a single clock domain is resolution: every output
    // edge lands on a clk edge, so duty and phase move in clk steps.
    always_ff @(posedge clk)
    begin
        if (!resetn)
            in_ff <= 1'b0;
        else
            in_ff <= distribution_input_clock;
    end

    assign in_rise = distribution_input_clock & ~in_ff;
    assign in_fall = ~distribution_input_clock & in_ff;

    // Both channels down puts the whole section asleep.
    // Sleep also holds the dividers at zero, which saves the most power
    // but loses the phase that the channels had before.
    assign sleep = settings_ff[SET_PD0_BIT] & settings_ff[SET_PD1_BIT];

    // Receiver choice and sleep state go straight to the analog side.
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            hf_receiver_sel <= 1'b0;
            deep_sleep      <= 1'b0;
        end
        else
        begin
            hf_receiver_sel <= settings_ff[SET_HF_RX_BIT];
            deep_sleep      <= sleep;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel dividers and drivers
    // ------------------------------------------------------------------
    // Each channel counts input rises from zero up to its ratio value,
    // so one output period spans value plus one input periods. Even
    // ratios hold the wave high for the first half of the counts. Odd
    // ratios rise at count zero and fall on the input fall inside the
    // middle count, which stretches the high time by the input's own
    // high fraction; that is where the duty correction comes from. A
    // ratio of one copies the sampled input. Deep sleep clears both
    // counters together, so equal ratios restart in step on wake.
    logic [DIV_W-1:0] cnt_ff   [NUM_CH];
    logic [DIV_W-1:0] ratio_ff [NUM_CH];
    logic [NUM_CH-1:0] wave_ff;

    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
        logic             boundary;
        logic [DIV_W-1:0] nxt_cnt;
        logic [DIV_W-1:0] nxt_ratio;
        logic             gated;
        logic             lvl;
        logic             pd;
        chan_mode_s       m;

        assign m         = mode_ff[c];
        assign pd        = settings_ff[c];
        assign boundary  = (cnt_ff[c] == ratio_ff[c]);
        // A new ratio is only taken where the old period ends.
        assign nxt_ratio = boundary ? divider_ff[c] : ratio_ff[c];
        assign nxt_cnt   = boundary ? '0 : cnt_ff[c] + 1'b1;

        // Counter advances on each input rise; all channels share the
        // same reset and input, so equal ratios stay in step.
        // A new value written mid-period waits for the boundary, so a
        // ratio change never shortens the running period.
        always_ff @(posedge clk)
        begin
            if (!resetn || sleep)
            begin
                cnt_ff[c]   <= '0;
                ratio_ff[c] <= DIVIDER_RST[DIV_W-1:0];
            end
            else if (in_rise)
            begin
                cnt_ff[c]   <= nxt_cnt;
                ratio_ff[c] <= nxt_ratio;
            end
        end

        // Divided wave before gating and polarity.
        always_ff @(posedge clk)
        begin
            if (!resetn || sleep)
                wave_ff[c] <= 1'b0;
            else if (ratio_ff[c] == '0 && nxt_ratio == '0)
                wave_ff[c] <= distribution_input_clock;
            else if (in_rise && nxt_ratio[0])
                wave_ff[c] <= (nxt_cnt <= (nxt_ratio >> 1));
            // An odd ratio only rises at count zero; later rises keep
            // the wave, and the fall below ends the high phase.
            else if (in_rise && nxt_cnt == '0)
                wave_ff[c] <= 1'b1;
            else if (in_fall && !ratio_ff[c][0]
                     && cnt_ff[c] == (ratio_ff[c] >> 1))
                wave_ff[c] <= 1'b0;
        end

        // Enable is taken while the wave is low at a period edge, so no
        // truncated pulse ever leaves; a bypassed channel uses the fall.
        // Equal ratios share boundaries, so channels enabled by one
        // write start and stop on the same input rise.
        always_ff @(posedge clk)
        begin
            if (!resetn)
                active_ff[c] <= 1'b0;
            else if (ratio_ff[c] == '0 ? in_fall : (in_rise && boundary))
                active_ff[c] <= enable_ff[c];
        end

        // A disabled channel stalls low before polarity: a static level.
        assign gated = wave_ff[c] & active_ff[c];
        assign lvl   = gated ^ m.polarity_inv;

        // Pin drivers; tristate and single-channel power-down never touch the divider.
        // CMOS codes drive one or both pins with the same level, or the
        // negative pin inverted when phase invert is set. LVDS and
        // LVPECL always drive a complementary pair. Tristate and the two
        // unused codes release both pins. Power-down only raises the
        // output enables, so a channel comes back already in phase.
        // The drive strength bit reaches CMOS and LVDS; LVPECL keeps it
        // low because its current is fixed.
        always_ff @(posedge clk)
        begin
            if (!resetn)
                channel_output[c] <= '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
            else
            begin
                channel_output[c].channel_positive_pin <= lvl;
                channel_output[c].channel_negative_pin <= lvl;
                channel_output[c].positive_oe_n        <= 1'b1;
                channel_output[c].negative_oe_n        <= 1'b1;
                channel_output[c].strong_drive         <= 1'b0;
                unique case (m.mode)
                    MODE_CMOS_BOTH, MODE_CMOS_POS, MODE_CMOS_NEG:
                    begin
                        channel_output[c].channel_negative_pin <=
                            lvl ^ m.cmos_phase_inv;
                        channel_output[c].positive_oe_n <=
                            pd | (m.mode == MODE_CMOS_NEG);
                        channel_output[c].negative_oe_n <=
                            pd | (m.mode == MODE_CMOS_POS);
                        channel_output[c].strong_drive <=
                            m.strong_drive;
                    end
                    MODE_LVDS:
                    begin
                        channel_output[c].channel_negative_pin <= ~lvl;
                        channel_output[c].positive_oe_n <= pd;
                        channel_output[c].negative_oe_n <= pd;
                        channel_output[c].strong_drive <=
                            m.strong_drive;
                    end
                    MODE_LVPECL:
                    begin
                        channel_output[c].channel_negative_pin <= ~lvl;
                        channel_output[c].positive_oe_n <= pd;
                        channel_output[c].negative_oe_n <= pd;
                    end
                    MODE_TRISTATE, MODE_UNUSED6, MODE_UNUSED7:
                    begin
                        channel_output[c].positive_oe_n <= 1'b1;
                        channel_output[c].negative_oe_n <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // output_clock_divider_distribution
`default_nettype wire

// *** tb/clkdist_asserts.sv ***
// Port-level assertion checker for the clock distribution block.
`timescale 1ns/1ps
`default_nettype none
module clkdist_asserts
    import clkdist_pkg::*;
#(
    parameter int unsigned NUM_CH = 2,
    parameter int unsigned DIV_W  = 30
)
(
    input wire logic                    clk,
    input wire logic                    resetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [ADDR_W-1:0]       paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire logic                    distribution_input_clock,
    input wire logic                    hf_receiver_sel,
    input wire logic                    deep_sleep,
    input wire chan_pins_s [NUM_CH-1:0] channel_output
);
    logic [2:0] quiet_ff;
    logic       wr_set;

    // Idle-bus counter; register writes may legally move the pins.
    always_ff @(posedge clk)
    begin
        if (!resetn || psel)
            quiet_ff <= 3'h0;
        else if (quiet_ff != 3'h7)
            quiet_ff <= quiet_ff + 3'h1;
    end

    // A completed write to the settings register.
    assign wr_set = psel && penable && pready && pwrite && paddr == 13'h1000;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    a_pready_follows: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_single: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside access");
    a_hf_follows: assert property (wr_set |-> ##2
        hf_receiver_sel == $past(pwdata[4], 2))
        else $error("receiver select wrong");
    a_sleep_follows: assert property (wr_set |-> ##2
        deep_sleep == ($past(pwdata[1], 2) && $past(pwdata[0], 2)))
        else $error("deep sleep wrong");
    a_sleep_tristate: assert property (deep_sleep && $past(deep_sleep) |->
        channel_output[0].positive_oe_n && channel_output[0].negative_oe_n
        && channel_output[1].positive_oe_n && channel_output[1].negative_oe_n)
        else $error("pins driven in deep sleep");
    a_edge_cause: assert property (
        $changed(channel_output[0].channel_positive_pin) && quiet_ff == 3'h7
        |-> $past(distribution_input_clock, 2)
            != $past(distribution_input_clock, 3))
        else $error("output edge without input edge");
endmodule // clkdist_asserts
`default_nettype wire

// *** tb/clock_receiver_model.sv ***
// Downstream receiver model: terminates and resolves the output pins.
`timescale 1ns/1ps
`default_nettype none
module clock_receiver_model
    import clkdist_pkg::*;
(
    input wire chan_pins_s [1:0] channel_output,
    output logic [1:0]           line_pos,
    output logic [1:0]           line_neg
);
    // Pull-down terminations take an undriven line low.
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            line_pos[i] = !channel_output[i].positive_oe_n
                && channel_output[i].channel_positive_pin;
            line_neg[i] = !channel_output[i].negative_oe_n
                && channel_output[i].channel_negative_pin;
        end
    end
endmodule // clock_receiver_model
`default_nettype wire

// *** tb/output_clock_divider_distribution_bench.sv ***
// Self-checking bench for the output clock distribution block.
`timescale 1ns/1ps
`default_nettype none
module output_clock_divider_distribution_bench
    import clkdist_pkg::*;
;
    logic        clk = 1'b0, resetn = 1'b0, in_clk = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [12:0] paddr = 13'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, hf_receiver_sel, deep_sleep, er;
    logic [1:0]  ph = 2'h0, line_pos, line_neg;
    chan_pins_s [1:0] channel_output;
    chan_pins_s  p;
    int          n_errors = 0, compares = 0, hi, mis, n;

    always #4 clk = ~clk;
    // Input is high one clk in four, so odd-ratio correction is visible.
    always @(posedge clk)
    begin
        ph <= ph + 2'h1;
        in_clk <= (ph == 2'h3);
    end

    output_clock_divider_distribution dut (.clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .distribution_input_clock(in_clk), .hf_receiver_sel, .deep_sleep,
        .channel_output);
    clock_receiver_model rx (.channel_output, .line_pos, .line_neg);

    task automatic close_out;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    // One APB transfer; the request holds until pready is sampled high.
    task automatic apb(input logic w, input logic [11:0] i, logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i[10:0], 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        if (k >= 16)
        begin
            n_errors++;
            close_out();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // Counts high cycles of a channel and cycles where channels differ.
    task automatic scan(input int ch, input int len);
        hi = 0;
        mis = 0;
        repeat (len)
        begin
            @(posedge clk);
            hi += line_pos[ch];
            mis += (line_pos[0] !== line_pos[1]);
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        apb(1'b0, IDX_SETTINGS, 32'h0);
        chk("settings", 32'h0, rd);
        apb(1'b0, IDX_ENABLE, 32'h0);
        chk("enable", 32'h3, rd);
        apb(1'b0, IDX_CH0_MODE, 32'h0);
        chk("mode0", 32'h0, rd);
        apb(1'b0, 12'h7FF, 32'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        // Every ratio from bypass to five; window is two output periods.
        for (int v = 0; v < 5; v++)
        begin
            apb(1'b1, IDX_CH0_DIVIDER, v);
            n = v + 1;
            repeat (8 * n + 24) @(posedge clk);
            scan(0, 8 * n);
            chk("duty", n == 1 ? 2 : n % 2 == 0 ? 4 * n : 4 * n - 2, hi);
        end
        apb(1'b1, IDX_CH0_MODE, 32'h10);
        repeat (40) @(posedge clk);
        scan(0, 40);
        chk("inverted", 22, hi);
        apb(1'b1, IDX_CH0_MODE, 32'h0);
        // Every mode code on channel one, strong drive requested.
        for (int m = 0; m < 8; m++)
        begin
            apb(1'b1, IDX_CH1_MODE, 32'h8 | m);
            repeat (4) @(posedge clk);
            p = channel_output[1];
            chk("pos_oe", !(m inside {0, 1, 4, 5}), p.positive_oe_n);
            chk("neg_oe", !(m inside {0, 2, 4, 5}), p.negative_oe_n);
            if (m inside {0, 1, 2, 4, 5})
                chk("strong", m != 5, p.strong_drive);
            if (m inside {0, 4, 5})
                chk("neg_rel", m != 0, p.channel_positive_pin ^ p.channel_negative_pin);
        end
        apb(1'b1, IDX_CH1_MODE, 32'h20);
        repeat (4) @(posedge clk);
        chk("phase", 1, channel_output[1].channel_positive_pin ^ channel_output[1].channel_negative_pin);
        apb(1'b1, IDX_CH1_MODE, 32'h0);
        apb(1'b1, IDX_SETTINGS, 32'h1);
        repeat (4) @(posedge clk);
        chk("pd", 32'hC, {channel_output[0].positive_oe_n, channel_output[0].negative_oe_n, channel_output[1].positive_oe_n, deep_sleep});
        apb(1'b1, IDX_CH0_DIVIDER, 32'h3);
        apb(1'b1, IDX_CH1_DIVIDER, 32'h3);
        apb(1'b1, IDX_SETTINGS, 32'h3);
        repeat (40) @(posedge clk);
        chk("sleep", 1, deep_sleep);
        apb(1'b1, IDX_SETTINGS, 32'h10);
        repeat (40) @(posedge clk);
        chk("wake_hf", 32'h1, {deep_sleep, hf_receiver_sel});
        scan(0, 64);
        chk("align_hi", 32, hi);
        chk("align_mis", 0, mis);
        apb(1'b1, IDX_ENABLE, 32'h2);
        repeat (40) @(posedge clk);
        scan(0, 32);
        chk("stall", 0, hi);
        apb(1'b0, IDX_STATUS, 32'h0);
        chk("status", 32'h2, rd);
        apb(1'b1, IDX_ENABLE, 32'h3);
        repeat (40) @(posedge clk);
        scan(0, 64);
        chk("rejoin", 0, mis);
        apb(1'b1, IDX_CH0_MODE, 32'h3);
        repeat (8) @(posedge clk);
        chk("tristate", 1, channel_output[0].positive_oe_n);
        apb(1'b1, IDX_CH0_MODE, 32'h0);
        repeat (8) @(posedge clk);
        scan(0, 64);
        chk("kept", 0, mis);
        apb(1'b1, IDX_CH1_DIVIDER, 32'hFFFF_FFFF);
        apb(1'b0, IDX_CH1_DIVIDER, 32'h0);
        chk("divwidth", 32'h3FFF_FFFF, rd);
        close_out();
    end
endmodule // output_clock_divider_distribution_bench

bind output_clock_divider_distribution clkdist_asserts #(.NUM_CH(NUM_CH),
    .DIV_W(DIV_W)) u_chk (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .distribution_input_clock,
    .hf_receiver_sel, .deep_sleep, .channel_output);
`default_nettype wire
